/* File: ptpc_consts.svh */
// offsets, field positions, reset values for the timestamp config registers
// assumes apb byte addressing with 32-bit aligned words
`ifndef PTPC_CONSTS_SVH
`define PTPC_CONSTS_SVH
`define PTPC_OFF_USER_HI 12'h14c
`define PTPC_OFF_USER_LO 12'h150
`define PTPC_OFF_SELECT 12'h154
`define PTPC_OFF_LATENCY 12'h158
`define PTPC_OFF_ASYM 12'h15c
`define PTPC_OFF_CMD_CTL 12'h100
`define PTPC_OFF_RX_PARSE 12'h158
`define PTPC_SEL_PIN_HI 10
`define PTPC_SEL_PIN_LO 8
`define PTPC_SEL_PORT_HI 5
`define PTPC_SEL_PORT_LO 4
`define PTPC_SEL_GRP_HI 2
`define PTPC_SEL_GRP_LO 0
`define PTPC_SEL_MASK 32'h0000073f
`define PTPC_USER_HI_MASK 32'h0000ffff
`define PTPC_CMD_ENABLE_BIT 2
`define PTPC_CMD_PEER_BIT 3
`define PTPC_CMD_MASK 32'h0000000c
`define PTPC_RX_USER_EN_BIT 8
`define PTPC_LAT_P0 16'h0014
`define PTPC_LAT_TX_PX 16'h005f
`define PTPC_LAT_RX_PX 16'h011d
`endif

/* File: ptpc_pkg.sv */
// types shared by the timestamp config register block
// assumes ptpc_consts.svh defines the numeric constants
package ptpc_pkg;
  typedef enum logic [2:0] {
    PTPC_GRP_GENERAL = 3'h0,
    PTPC_GRP_RX = 3'h1,
    PTPC_GRP_TX = 3'h2,
    PTPC_GRP_PIN = 3'h3
  } ptpc_group_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ptpc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ptpc_apb_rsp_t;
  typedef struct packed {
    logic [15:0] tx_ns;
    logic [15:0] rx_ns;
  } ptpc_latency_t;
  typedef struct packed {
    logic [15:0] asym_ns;
    logic [15:0] peer_ns;
  } ptpc_asym_t;
endpackage

/* File: ptpc_port_corr.sv */
// one port's latency correction of a captured clock value
// assumes the capture value arrives on the same clock
`timescale 1ns/1ns
module ptpc_port_corr #(
  parameter int TS_W = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic capture_valid,
  input wire logic capture_is_tx,
  input wire logic [TS_W-1:0] capture_ns,
  input wire ptpc_pkg::ptpc_latency_t latency,
  output logic [TS_W-1:0] stamp_ns_r,
  output logic stamp_valid_r
);
  import ptpc_pkg::*;
  // medium-referenced stamp
  // egress is seen inside before the medium, ingress after it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stamp_ns_r <= '0;
      stamp_valid_r <= 1'b0;
    end else if (clk_en) begin
      stamp_valid_r <= capture_valid;
      if (capture_valid) begin
        if (capture_is_tx) begin
          stamp_ns_r <= capture_ns + TS_W'(latency.tx_ns);
        end else begin
          stamp_ns_r <= capture_ns - TS_W'(latency.rx_ns);
        end
      end
    end
  end
endmodule // ptpc_port_corr

/* File: ptpc_regs.sv */
// apb register bank: user address, bank/port/pin select, per-port latency and asymmetry
// assumes apb master on the same clock; capture values come from the timestamp unit
// Functional notes
// - low-word register holds address bits 31:0 of 48-bit user address
// - high register bits 15:0 give address bits 47:32
// - user address matching only where the protocol's enable bit is set
// - select bits 10:8 pick the pin instance, reset zero
// - select bits 5:4 pick the port instance, reset zero
// - select bits 2:0 pick bank: general, rx, tx, pin; 1xx reserved
// - latency bits 31:16 hold egress delay in ns
// - latency bits 15:0 hold ingress delay in ns
// - captured clock values corrected by the port latency
// - latency resets 20/20 port 0, 95 tx and 285 rx others
// - asymmetry bits 31:16 signed ns, reset zero
// - asymmetry bits 15:0 peer delay ns, reset zero, used in peer mode
`timescale 1ns/1ns
`include "ptpc_consts.svh"
module ptpc_regs #(
  parameter int NUM_PORTS = 3,
  parameter int TS_W = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire ptpc_pkg::ptpc_apb_req_t apb_req,
  output ptpc_pkg::ptpc_apb_rsp_t apb_rsp,
  input wire logic [NUM_PORTS-1:0] capture_valid,
  input wire logic [NUM_PORTS-1:0] capture_is_tx,
  input wire logic [NUM_PORTS*TS_W-1:0] capture_ns,
  output logic [NUM_PORTS*TS_W-1:0] stamp_ns,
  output logic [NUM_PORTS-1:0] stamp_valid,
  output logic [47:0] user_addr,
  output logic [NUM_PORTS-1:0] user_addr_match_en,
  output logic timestamp_enable,
  output logic [2:0] pin_index,
  output logic [1:0] port_index,
  output ptpc_pkg::ptpc_group_t reg_group,
  output ptpc_pkg::ptpc_asym_t [NUM_PORTS-1:0] port_asym,
  output logic peer_mode
);
  import ptpc_pkg::*;

  logic [31:0] user_addr_low_word_r;
  logic [15:0] user_addr_high_word_r;
  logic [31:0] bank_port_pin_select_r;
  logic [31:0] timestamp_command_control_r;
  logic [NUM_PORTS-1:0] receive_parse_config_r;
  ptpc_latency_t port_latency_r [NUM_PORTS];
  ptpc_asym_t port_asymmetry_peer_delay_r [NUM_PORTS];
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_en;
  logic addr_ok;
  logic [1:0] psel_port;
  logic [2:0] psel_grp;

  // single-cycle access phase: pready high whenever penable is
  assign wr_en = clk_en && apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign psel_port = bank_port_pin_select_r[`PTPC_SEL_PORT_HI:`PTPC_SEL_PORT_LO];
  assign psel_grp = bank_port_pin_select_r[`PTPC_SEL_GRP_HI:`PTPC_SEL_GRP_LO];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      user_addr_low_word_r <= 32'h00000000;
    end else if (wr_en && apb_req.paddr == `PTPC_OFF_USER_LO) begin
      user_addr_low_word_r <= apb_req.pwdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      user_addr_high_word_r <= 16'h0000;
    end else if (wr_en && apb_req.paddr == `PTPC_OFF_USER_HI) begin
      user_addr_high_word_r <= apb_req.pwdata[15:0];
    end
  end

  // select fields, reserved bits other than bit 3 masked off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bank_port_pin_select_r <= 32'h00000000;
    end else if (wr_en && apb_req.paddr == `PTPC_OFF_SELECT) begin
      bank_port_pin_select_r <= apb_req.pwdata & `PTPC_SEL_MASK;
    end
  end

  // minimal command word: only the enable and peer-mode bits are kept here
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timestamp_command_control_r <= 32'h00000000;
    end else if (wr_en && apb_req.paddr == `PTPC_OFF_CMD_CTL) begin
      timestamp_command_control_r <= apb_req.pwdata & `PTPC_CMD_MASK;
    end
  end

  // per-port banked registers, selected by port index and group
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (i == 0) begin
          port_latency_r[i] <= '{tx_ns: `PTPC_LAT_P0, rx_ns: `PTPC_LAT_P0};
        end else begin
          port_latency_r[i] <= '{tx_ns: `PTPC_LAT_TX_PX, rx_ns: `PTPC_LAT_RX_PX};
        end
        port_asymmetry_peer_delay_r[i] <= '0;
        receive_parse_config_r[i] <= 1'b0;
      end
    end else if (wr_en && 32'(psel_port) < NUM_PORTS) begin
      if (psel_grp == 3'(PTPC_GRP_GENERAL) && apb_req.paddr == `PTPC_OFF_LATENCY) begin
        port_latency_r[psel_port] <= apb_req.pwdata;
      end
      if (psel_grp == 3'(PTPC_GRP_GENERAL) && apb_req.paddr == `PTPC_OFF_ASYM) begin
        port_asymmetry_peer_delay_r[psel_port] <= apb_req.pwdata;
      end
      if (psel_grp == 3'(PTPC_GRP_RX) && apb_req.paddr == `PTPC_OFF_RX_PARSE) begin
        receive_parse_config_r[psel_port] <= apb_req.pwdata[`PTPC_RX_USER_EN_BIT];
      end
    end
  end

  // read mux; unmapped or reserved-bank reads return zero with pslverr
  always_comb begin
    rdata_nxt = 32'h00000000;
    addr_ok = 1'b1;
    case (apb_req.paddr)
      `PTPC_OFF_USER_LO: rdata_nxt = user_addr_low_word_r;
      `PTPC_OFF_USER_HI: rdata_nxt = {16'h0000, user_addr_high_word_r};
      `PTPC_OFF_SELECT: rdata_nxt = bank_port_pin_select_r;
      `PTPC_OFF_CMD_CTL: rdata_nxt = timestamp_command_control_r;
      `PTPC_OFF_LATENCY: begin
        if (32'(psel_port) >= NUM_PORTS) begin
          addr_ok = 1'b0;
        end else if (psel_grp == 3'(PTPC_GRP_GENERAL)) begin
          rdata_nxt = port_latency_r[psel_port];
        end else if (psel_grp == 3'(PTPC_GRP_RX)) begin
          rdata_nxt = 32'(receive_parse_config_r[psel_port]) << `PTPC_RX_USER_EN_BIT;
        end else begin
          addr_ok = 1'b0;
        end
      end
      `PTPC_OFF_ASYM: begin
        if (32'(psel_port) < NUM_PORTS && psel_grp == 3'(PTPC_GRP_GENERAL)) begin
          rdata_nxt = port_asymmetry_peer_delay_r[psel_port];
        end else begin
          addr_ok = 1'b0;
        end
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // read data registered at the setup-phase edge (psel high, penable low) so it is a flip-flop output
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h00000000;
    end else if (clk_en && apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      rdata_r <= rdata_nxt;
    end
  end

  // zero-wait: setup captures read data, access completes at once
  assign apb_rsp.prdata = rdata_r;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;

  assign timestamp_enable = timestamp_command_control_r[`PTPC_CMD_ENABLE_BIT];
  assign user_addr = {user_addr_high_word_r, user_addr_low_word_r};
  // match only where the protocol enables it
  assign user_addr_match_en = receive_parse_config_r & {NUM_PORTS{timestamp_enable}};
  assign pin_index = bank_port_pin_select_r[`PTPC_SEL_PIN_HI:`PTPC_SEL_PIN_LO];
  assign port_index = psel_port;
  // group code, reserved codes passed through as read
  assign reg_group = ptpc_group_t'(psel_grp);
  // peer delay applies in peer mode
  assign peer_mode = timestamp_command_control_r[`PTPC_CMD_PEER_BIT];

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      assign port_asym[g] = port_asymmetry_peer_delay_r[g];
      ptpc_port_corr #(
        .TS_W(TS_W)
      ) u_corr (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .capture_valid(capture_valid[g]),
        .capture_is_tx(capture_is_tx[g]),
        .capture_ns(capture_ns[g*TS_W +: TS_W]),
        .latency(port_latency_r[g]),
        .stamp_ns_r(stamp_ns[g*TS_W +: TS_W]),
        .stamp_valid_r(stamp_valid[g])
      );
    end
  endgenerate
endmodule // ptpc_regs

/* File: ptpc_cap_src.sv */
// far-side model: the capture logic that hands raw clock values to each port
// assumes requests from the bench arrive on the rising edge of clock
`timescale 1ns/1ns
module ptpc_cap_src #(
  parameter int N = 3,
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [1:0] cport,
  input wire logic cdir,
  input wire logic [W-1:0] cval,
  output logic [N-1:0] capture_valid,
  output logic [N-1:0] capture_is_tx,
  output logic [N*W-1:0] capture_ns
);
  // raw capture pulse
  // idle lanes toggle so a design that ignores valid is caught
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      capture_valid <= '0;
      capture_is_tx <= '0;
      capture_ns <= '0;
    end else begin
      capture_valid <= '0;
      capture_is_tx <= ~capture_is_tx;
      capture_ns <= ~capture_ns;
      if (go) begin
        capture_valid[cport] <= 1'b1;
        capture_is_tx[cport] <= cdir;
        capture_ns[cport*W +: W] <= cval;
      end
    end
  end
endmodule // ptpc_cap_src

/* File: ptpc_regs_properties.sv */
// checker for the timestamp config register bank
// assumes zero-wait apb on clock, bound to ptpc_regs
`timescale 1ns/1ns
`include "ptpc_consts.svh"
module ptpc_regs_chk #(
  parameter int NUM_PORTS = 3,
  parameter int TS_W = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire ptpc_pkg::ptpc_apb_req_t apb_req,
  input wire ptpc_pkg::ptpc_apb_rsp_t apb_rsp,
  input wire logic [NUM_PORTS-1:0] capture_valid,
  input wire logic [NUM_PORTS-1:0] stamp_valid,
  input wire logic [47:0] user_addr,
  input wire logic [NUM_PORTS-1:0] user_addr_match_en,
  input wire logic timestamp_enable,
  input wire logic [2:0] pin_index,
  input wire logic [1:0] port_index,
  input wire ptpc_pkg::ptpc_group_t reg_group,
  input wire ptpc_pkg::ptpc_asym_t [NUM_PORTS-1:0] port_asym,
  input wire logic peer_mode
);
  import ptpc_pkg::*;
  logic wr;
  logic rd;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & clk_en;
  assign rd = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_lo;
    wr && apb_req.paddr == `PTPC_OFF_USER_LO |=> user_addr[31:0] == $past(apb_req.pwdata);
  endproperty
  a_lo: assert property (p_lo) else $error("low address word not taken");
  property p_hi;
    wr && apb_req.paddr == `PTPC_OFF_USER_HI |=> user_addr[47:32] == $past(apb_req.pwdata[15:0]);
  endproperty
  a_hi: assert property (p_hi) else $error("high address word not taken");
  property p_pin;
    wr && apb_req.paddr == `PTPC_OFF_SELECT |=> pin_index == $past(apb_req.pwdata[10:8]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin index wrong");
  property p_port;
    wr && apb_req.paddr == `PTPC_OFF_SELECT |=> port_index == $past(apb_req.pwdata[5:4]);
  endproperty
  a_port: assert property (p_port) else $error("port index wrong");
  property p_grp;
    wr && apb_req.paddr == `PTPC_OFF_SELECT |=> reg_group == $past(apb_req.pwdata[2:0]);
  endproperty
  a_grp: assert property (p_grp) else $error("bank group wrong");
  property p_bank_err;
    rd && apb_req.paddr == `PTPC_OFF_ASYM && reg_group != PTPC_GRP_GENERAL |-> apb_rsp.pslverr;
  endproperty
  a_bank_err: assert property (p_bank_err) else $error("banked access outside bank 0 not refused");
  property p_rsv;
    rd && apb_req.paddr == `PTPC_OFF_SELECT |-> (apb_rsp.prdata & ~32'h0000073f) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved select bits not zero");
  property p_match;
    |user_addr_match_en |-> timestamp_enable;
  endproperty
  a_match: assert property (p_match) else $error("match enabled with unit off");
  property p_stamp;
    clk_en && |capture_valid |=> stamp_valid == $past(capture_valid);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp pulse missing");
  property p_asym;
    wr && apb_req.paddr == `PTPC_OFF_ASYM && reg_group == PTPC_GRP_GENERAL && port_index == 2'h0
      |=> port_asym[0] == $past(apb_req.pwdata);
  endproperty
  a_asym: assert property (p_asym) else $error("asymmetry not taken");
  property p_peer;
    wr && apb_req.paddr == `PTPC_OFF_CMD_CTL |=> peer_mode == $past(apb_req.pwdata[`PTPC_CMD_PEER_BIT]);
  endproperty
  a_peer: assert property (p_peer) else $error("peer mode bit not taken");
  c_lo: cover property (wr && apb_req.paddr == `PTPC_OFF_USER_LO);
  c_err: cover property (apb_rsp.pslverr);
  c_stamp: cover property (|stamp_valid);
endmodule // ptpc_regs_chk
bind ptpc_regs ptpc_regs_chk #(.NUM_PORTS(NUM_PORTS), .TS_W(TS_W)) ptpc_regs_chk_inst (
  .clock, .reset_n, .clk_en, .apb_req, .apb_rsp, .capture_valid, .stamp_valid, .user_addr,
  .user_addr_match_en, .timestamp_enable, .pin_index, .port_index, .reg_group, .port_asym, .peer_mode);

/* File: tb_top.sv */
// self-checking bench for the timestamp config register bank
// assumes zero-wait apb slave and a one-cycle capture correction path
`timescale 1ns/1ns
`include "ptpc_consts.svh"
module tb_top;
  import ptpc_pkg::*;
  logic clock, reset_n, clk_en, go, cdir, e, timestamp_enable, peer_mode;
  logic [1:0] cport, port_index;
  logic [2:0] capture_valid, capture_is_tx, stamp_valid, user_addr_match_en, pin_index;
  logic [31:0] cval, q, v, seed, a0;
  logic [95:0] capture_ns, stamp_ns;
  logic [47:0] user_addr;
  ptpc_apb_req_t apb_req;
  ptpc_apb_rsp_t apb_rsp;
  ptpc_group_t reg_group;
  ptpc_asym_t [2:0] port_asym;
  logic [31:0] lat [3];
  int n_fail, cmp_count;
  ptpc_regs ptpc_regs_inst (.clock, .reset_n, .clk_en, .apb_req, .apb_rsp, .capture_valid, .capture_is_tx,
    .capture_ns, .stamp_ns, .stamp_valid, .user_addr, .user_addr_match_en, .timestamp_enable, .pin_index,
    .port_index, .reg_group, .port_asym, .peer_mode);
  ptpc_cap_src ptpc_cap_src_inst (.clock, .reset_n, .go, .cport, .cdir, .cval, .capture_valid,
    .capture_is_tx, .capture_ns);
  task automatic end_sim;
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask
  function automatic logic [31:0] exp_st(input logic [31:0] r, input logic [31:0] l, input logic tx);
    return tx ? r + {16'h0, l[31:16]} : r - {16'h0, l[15:0]};
  endfunction
  task automatic cap(input int p, input logic tx);
    @(posedge clock);
    go <= 1'b1;
    cport <= p[1:0];
    cdir <= tx;
    cval <= $random(seed);
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(negedge clock);
    chk(32'(stamp_valid), clk_en ? 32'(3'h1 << p) : 32'h0);
    if (clk_en) chk(stamp_ns[p*32 +: 32], exp_st(cval, lat[p], tx));
    @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
  initial begin
    {reset_n, go, cport, cdir, cval, n_fail, cmp_count} = '0;
    clk_en = 1'b1;
    apb_req = '0;
    seed = 32'h3399;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rd(`PTPC_OFF_USER_LO, 32'h0, 1'b0);
    rd(`PTPC_OFF_USER_HI, 32'h0, 1'b0);
    rd(`PTPC_OFF_SELECT, 32'h0, 1'b0);
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, `PTPC_OFF_SELECT, p << 4);
      rd(`PTPC_OFF_LATENCY, p == 0 ? 32'h00140014 : 32'h005f011d, 1'b0);
      rd(`PTPC_OFF_ASYM, 32'h0, 1'b0);
    end
    v = $random(seed);
    lat = '{32'h00000014, 32'h0473068a, {16'h0044 + v[7:0], 16'h00e7 + v[7:0]}};
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, `PTPC_OFF_SELECT, p << 4);
      apb(1'b1, `PTPC_OFF_LATENCY, lat[p]);
      rd(`PTPC_OFF_LATENCY, lat[p], 1'b0);
      cap(p, 1'b1);
      cap(p, 1'b0);
      v = $random(seed);
      if (p == 0) a0 = v;
      apb(1'b1, `PTPC_OFF_ASYM, v);
      rd(`PTPC_OFF_ASYM, v, 1'b0);
      chk(port_asym[p], v);
    end
    apb(1'b1, `PTPC_OFF_SELECT, 32'h30);
    rd(`PTPC_OFF_LATENCY, 32'h0, 1'b1);
    for (int g = 0; g < 8; g++) begin
      v = $random(seed);
      v[5:0] = {2'h0, v[3], g[2:0]};
      apb(1'b1, `PTPC_OFF_SELECT, v);
      rd(`PTPC_OFF_SELECT, v & 32'h0000073f, 1'b0);
      chk(32'({pin_index, port_index, reg_group}), 32'({v[10:8], v[5:4], v[2:0]}));
      rd(`PTPC_OFF_ASYM, g == 0 ? a0 : 32'h0, g != 0);
    end
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'b1, `PTPC_OFF_USER_LO, v);
      rd(`PTPC_OFF_USER_LO, v, 1'b0);
      a0 = $random(seed);
      apb(1'b1, `PTPC_OFF_USER_HI, a0);
      rd(`PTPC_OFF_USER_HI, a0 & 32'h0000ffff, 1'b0);
      chk(user_addr[47:16], {a0[15:0], v[31:16]});
      chk(user_addr[31:0], v);
    end
    rd(12'h1f0, 32'h0, 1'b1);
    clk_en <= 1'b0;
    cap(0, 1'b1);
    clk_en <= 1'b1;
    apb(1'b1, `PTPC_OFF_SELECT, 32'h1);
    apb(1'b1, `PTPC_OFF_RX_PARSE, 32'h100);
    rd(`PTPC_OFF_RX_PARSE, 32'h100, 1'b0);
    chk(32'(user_addr_match_en), 32'h0);
    apb(1'b1, `PTPC_OFF_CMD_CTL, 32'hfffffffc);
    rd(`PTPC_OFF_CMD_CTL, 32'h0000000c, 1'b0);
    chk(32'({timestamp_enable, peer_mode}), 32'h3);
    chk(32'(user_addr_match_en), 32'h1);
    // no field writes once the unit is enabled
    end_sim();
  end
endmodule // tb_top
